// [design/factory_info_pkg.sv]
// Package with the map, protection codes and request carriers of the factory information region.
package factory_info_pkg;

  // ==========================================================================
  // Widths and address map
  // ==========================================================================
  localparam int WORD_W = 32;
  localparam int ADDR_W = 9;
  localparam int STORE_DEPTH = 12;
  localparam int STORE_IDX_W = 4;
  localparam logic [ADDR_W-1:0] UNIQUE_ID_BASE = 9'h0D0;
  localparam logic [ADDR_W-1:0] UNIQUE_ID_END = 9'h0E0;
  localparam logic [ADDR_W-1:0] REGION_GUARD_BASE = 9'h100;
  localparam logic [ADDR_W-1:0] LINK_CIPHER_BASE = 9'h110;
  localparam logic [ADDR_W-1:0] HW_ADDR_BASE = 9'h120;
  localparam logic [ADDR_W-1:0] HW_ADDR_STRIDE = 9'h008;
  localparam logic [ADDR_W-1:0] STORE_END = 9'h130;
  localparam logic [ADDR_W-1:0] WORD_STRIDE = 9'h004;

  // Word indices inside the one-time-programmable store.
  localparam logic [STORE_IDX_W-1:0] GUARD_IDX0 = 4'h0;
  localparam logic [STORE_IDX_W-1:0] CIPHER_IDX0 = 4'h4;
  localparam logic [STORE_IDX_W-1:0] HW_ADDR_IDX0 = 4'h8;

  // ==========================================================================
  // Values of stored words and the reset synchronizer fill
  // ==========================================================================
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [WORD_W-1:0] GUARD_OPEN = 32'h50FA50FA;
  localparam logic [WORD_W-1:0] GUARD_LOCKED = 32'h00000000;
  localparam logic [1:0] RESET_SYNC_ONES = 2'h3;

  // Address byte lanes of the upper hardware address word.
  localparam int LANE_SIXTH = 0;
  localparam int LANE_FIFTH = 8;
  localparam int LANE_FOURTH = 16;
  localparam int LANE_THIRD = 24;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    GUARD_UNPROGRAMMED,
    GUARD_STATE_OPEN,
    GUARD_STATE_LOCKED
  } guard_state_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
    op_mode_t mode;
  } op_req_t;

  typedef struct packed {
    logic done;
    logic denied;
    logic [WORD_W-1:0] data;
  } op_rsp_t;

endpackage

// [design/factory_info_region.sv]
// Indirectly accessed factory and customer information region with protection control.
// Summary of operation
// - Unique identifier reads as four words from 0x0D0, one every four bytes.
// - Four protection words from 0x100 restrict access to the customer words.
// - Protection changes only when all four protection words hold one identical value.
// - The 128-bit link key is stored as four words from 0x110.
// - Key word zero holds bits 31:0, word three holds bits 127:96.
// - Each of two virtual interfaces has an address pair at 0x120 plus n times eight.
// - Upper address word holds sixth byte lowest, then fifth, fourth, third on top.
// - Unprogrammed protection blocks all reads and writes of customer words.
// - Open value grants full read and write of key and address words.
// - Zero value blocks key readout; address words readable but not writable.
module factory_info_region
  import factory_info_pkg::*;
#(
  parameter logic [4*WORD_W-1:0] FACTORY_UNIQUE_ID = 128'h0123456789ABCDEF0011223344556677 // Arbitrary value.
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_op_go,
  input wire op_req_t i_op,
  output op_rsp_t o_rsp,
  output guard_state_t o_guard_state,
  output logic [4*WORD_W-1:0] o_link_key
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_sync_q;
  logic rst_n;

  // The reset is asserted at once but released through two flops to avoid a ragged release.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  // Only the second flop feeds the logic, so a first stage caught mid-transition never reaches it.
  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // Request decoding
  // ==========================================================================
  logic word_aligned;
  logic in_unique_id;
  logic in_store;
  logic [ADDR_W-1:0] store_offset;
  logic [STORE_IDX_W-1:0] store_idx;
  logic in_guard;
  logic in_cipher;
  logic in_hw_addr;
  logic [1:0] unique_id_idx;

  // Word offsets: identifier at base plus n times four, store words likewise from 0x100.
  assign word_aligned = (i_op.addr[1:0] == 2'h0);
  assign in_unique_id = (i_op.addr >= UNIQUE_ID_BASE) && (i_op.addr < UNIQUE_ID_END);
  assign in_store = (i_op.addr >= REGION_GUARD_BASE) && (i_op.addr < STORE_END);
  assign store_offset = i_op.addr - REGION_GUARD_BASE;
  assign store_idx = store_offset[STORE_IDX_W+1:2];
  assign unique_id_idx = i_op.addr[3:2];
  assign in_guard = in_store && (i_op.addr < LINK_CIPHER_BASE);
  assign in_cipher = in_store && (i_op.addr >= LINK_CIPHER_BASE) && (i_op.addr < HW_ADDR_BASE);
  assign in_hw_addr = in_store && (i_op.addr >= HW_ADDR_BASE);

  // ==========================================================================
  // Protection state
  // ==========================================================================
  logic [STORE_DEPTH*WORD_W-1:0] store_words;
  logic guard_agree;
  guard_state_t guard_decoded;
  guard_state_t guard_state_q;
  guard_state_t guard_state_d;

  region_guard_decode u_guard_decode (
    .i_guard_words(store_words[0 +: 4*WORD_W]),
    .o_agree(guard_agree),
    .o_state(guard_decoded)
  );

  // A half-programmed set of guard words must never open or relax access.
  assign guard_state_d = guard_agree ? guard_decoded : guard_state_q;

  // The state starts blank and follows the stored words one cycle later.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_state_q <= GUARD_UNPROGRAMMED;
    end else begin
      guard_state_q <= guard_state_d;
    end
  end

  // ==========================================================================
  // Access permission
  // ==========================================================================
  logic is_open;
  logic is_locked;
  logic read_allowed;
  logic write_allowed;

  assign is_open = (guard_state_q == GUARD_STATE_OPEN);
  assign is_locked = (guard_state_q == GUARD_STATE_LOCKED);

  // Customer words are shut while blank; the key hides once locked, addresses stay readable.
  assign read_allowed = word_aligned && (in_unique_id || in_guard ||
                        (in_cipher && is_open) ||
                        (in_hw_addr && (is_open || is_locked)));

  // Guard words stay writable so a blank part can be opened; the identifier never is.
  assign write_allowed = word_aligned && (in_guard ||
                         ((in_cipher || in_hw_addr) && is_open));

  // ==========================================================================
  // Operation execution
  // ==========================================================================
  logic do_read;
  logic do_write;
  logic op_valid;
  logic store_wr_en;
  logic [WORD_W-1:0] read_word;
  op_rsp_t rsp_d;
  op_rsp_t rsp_q;

  // An idle or illegal mode code with the go strobe is answered as a refused operation.
  always_comb begin
    do_read = 1'b0;
    do_write = 1'b0;
    op_valid = 1'b0;
    unique case (i_op.mode)
      OP_READ: begin
        do_read = i_op_go;
        op_valid = 1'b1;
      end
      OP_WRITE: begin
        do_write = i_op_go;
        op_valid = 1'b1;
      end
      OP_IDLE: begin
        op_valid = 1'b0;
      end
      default: begin
        op_valid = 1'b0;
      end
    endcase
  end

  assign store_wr_en = do_write && write_allowed;

  otp_word_store #(
    .WIDTH(WORD_W),
    .DEPTH(STORE_DEPTH),
    .IDX_W(STORE_IDX_W)
  ) u_store (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_wr_en(store_wr_en),
    .i_wr_idx(store_idx),
    .i_wr_data(i_op.data),
    .o_words(store_words)
  );

  // Identifier words come from the factory value; a refused read returns all ones.
  assign read_word = !read_allowed ? ERASED_WORD :
                     in_unique_id ? FACTORY_UNIQUE_ID[unique_id_idx*WORD_W +: WORD_W] :
                     store_words[store_idx*WORD_W +: WORD_W];

  // Answer one cycle after the go strobe; writes echo nothing back.
  always_comb begin
    rsp_d.done = i_op_go;
    rsp_d.denied = i_op_go && (!op_valid || (do_read && !read_allowed) || (do_write && !write_allowed));
    rsp_d.data = do_read ? read_word : ERASED_WORD;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q <= '{done: 1'b0, denied: 1'b0, data: ERASED_WORD};
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ==========================================================================
  // Key delivery to the link cipher
  // ==========================================================================
  logic [4*WORD_W-1:0] link_key_q;

  // The cipher always sees the key, even when software readout is locked.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_key_q <= {4{ERASED_WORD}};
    end else begin
      link_key_q <= store_words[CIPHER_IDX0*WORD_W +: 4*WORD_W];
    end
  end

  assign o_rsp = rsp_q;
  assign o_guard_state = guard_state_q;
  assign o_link_key = link_key_q;

endmodule

// [design/otp_word_store.sv]
// One-time-programmable word store whose bits may only be cleared.
module otp_word_store
  import factory_info_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 12,
  parameter int IDX_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic [IDX_W-1:0] i_wr_idx,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic [DEPTH*WIDTH-1:0] o_words
);

  // ==========================================================================
  // Storage cells
  // ==========================================================================
  // A write can only pull ones to zero, as a fused cell would; a reset models a blank part.
  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    logic [WIDTH-1:0] cell_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cell_q <= WIDTH'(ERASED_WORD);
      end else if (i_wr_en && (i_wr_idx == IDX_W'(g))) begin
        cell_q <= cell_q & i_wr_data;
      end
    end
    assign o_words[g*WIDTH +: WIDTH] = cell_q;
  end

endmodule

// [design/region_guard_decode.sv]
// Comparison and decoding of the four region protection words.
module region_guard_decode
  import factory_info_pkg::*;
(
  input wire logic [4*WORD_W-1:0] i_guard_words,
  output logic o_agree,
  output guard_state_t o_state
);

  // ==========================================================================
  // Agreement and decoding
  // ==========================================================================
  // A value is only meaningful once every one of the four words holds it.
  logic [WORD_W-1:0] word0;
  assign word0 = i_guard_words[0 +: WORD_W];
  assign o_agree = (i_guard_words[WORD_W +: WORD_W] == word0) &&
                   (i_guard_words[2*WORD_W +: WORD_W] == word0) &&
                   (i_guard_words[3*WORD_W +: WORD_W] == word0);

  // Any agreed value other than the two codes grants nothing, like a blank part.
  assign o_state = (word0 == GUARD_OPEN) ? GUARD_STATE_OPEN :
                   (word0 == GUARD_LOCKED) ? GUARD_STATE_LOCKED : GUARD_UNPROGRAMMED;

endmodule

// [dv/factory_info_region_monitor.sv]
// Checker of response timing, refusals and protection changes of the information region.
module factory_info_region_monitor
  import factory_info_pkg::*;
#(
  parameter logic [4*WORD_W-1:0] FACTORY_UNIQUE_ID = '1
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_op_go,
  input wire op_req_t i_op,
  input wire op_rsp_t o_rsp,
  input wire guard_state_t o_guard_state,
  input wire logic [4*WORD_W-1:0] o_link_key
);
  // ==========================================================================
  // Request classes
  // ==========================================================================
  // Decoded once here so every property names the same address groups.
  wire logic aligned_go = i_op_go && i_op.addr[1:0] == 2'h0;
  wire logic id_rd = aligned_go && i_op.mode == OP_READ && i_op.addr[8:4] == 5'h0D;
  wire logic key_rd = aligned_go && i_op.mode == OP_READ && i_op.addr[8:4] == 5'h11;
  wire logic key_wr = aligned_go && i_op.mode == OP_WRITE && i_op.addr[8:4] == 5'h11;
  wire logic guard_wr = aligned_go && i_op.mode == OP_WRITE && i_op.addr[8:4] == 5'h10;
  wire logic hw_wr = aligned_go && i_op.mode == OP_WRITE && i_op.addr[8:4] == 5'h12;

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_refused;
    o_rsp.done && o_rsp.denied && o_rsp.data == ERASED_WORD;
  endsequence

  sequence s_granted;
    o_rsp.done && !o_rsp.denied;
  endsequence

  // Guard checks skip a request right after another, since a pending guard change may not show yet.
  chk_done_next_cycle: assert property (i_op_go |=> o_rsp.done)
    else $error("response did not follow the request");
  chk_no_stray_done: assert property (!i_op_go |=> !o_rsp.done)
    else $error("response without a request");
  chk_id_read_word: assert property (id_rd |=> s_granted ##0
    o_rsp.data == FACTORY_UNIQUE_ID[32*$past(i_op.addr[3:2]) +: 32])
    else $error("identifier word read wrong");
  chk_guard_always_writable: assert property (guard_wr |=> s_granted)
    else $error("protection word write refused");
  chk_key_read_guarded: assert property (key_rd && o_guard_state != GUARD_STATE_OPEN && !$past(i_op_go) |=> s_refused)
    else $error("key read allowed while not open");
  chk_hw_write_guarded: assert property (hw_wr && o_guard_state != GUARD_STATE_OPEN && !$past(i_op_go) |=> s_refused)
    else $error("address write allowed while not open");
  chk_state_cause: assert property ($changed(o_guard_state) |-> $past(guard_wr, 2))
    else $error("protection state changed without a protection write");
  chk_key_cause: assert property ($changed(o_link_key) |-> $past(key_wr) || $past(key_wr, 2))
    else $error("key output changed without a key write");
  chk_idle_refused: assert property (i_op_go && i_op.mode == OP_IDLE |=> s_refused)
    else $error("idle mode request not refused");
endmodule

bind factory_info_region factory_info_region_monitor #(.FACTORY_UNIQUE_ID(FACTORY_UNIQUE_ID)) mon (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .i_op_go(i_op_go),
  .i_op(i_op),
  .o_rsp(o_rsp),
  .o_guard_state(o_guard_state),
  .o_link_key(o_link_key)
);

// [dv/tb.sv]
// Self-checking testbench of the factory information region.
module tb
  import factory_info_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF; // Arbitrary value.
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_op_go = 1'b0;
  op_req_t i_op = '0;
  op_rsp_t o_rsp;
  guard_state_t o_guard_state;
  logic [127:0] o_link_key;
  logic [127:0] key;
  logic [31:0] hw;
  int err_total = 0;
  int samples_checked = 0;

  factory_info_region #(.FACTORY_UNIQUE_ID(UID)) dut (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_op_go(i_op_go),
    .i_op(i_op),
    .o_rsp(o_rsp),
    .o_guard_state(o_guard_state),
    .o_link_key(o_link_key)
  );

  // A 10 ns clock.
  always #5 i_core_clk = ~i_core_clk;

  // Identifier word n as the identifier parameter lays it out.
  function automatic logic [31:0] uid_word(input int n);
    return UID[32*n +: 32];
  endfunction

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request, entered at a falling edge; a spare cycle follows so requests never sit back to back.
  task automatic op(input op_mode_t m, input logic [8:0] a, input logic [31:0] d, input logic den,
                    input logic [31:0] ed);
    int k;
    k = 0;
    i_op_go = 1'b1;
    i_op = '{addr: a, data: d, mode: m};
    @(negedge i_core_clk);
    i_op_go = 1'b0;
    while (o_rsp.done !== 1'b1 && k < 4) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == 4) begin
      err_total++;
      tally_and_finish();
    end
    check({31'h0, o_rsp.denied}, {31'h0, den});
    check(o_rsp.data, ed);
    @(negedge i_core_clk);
  endtask

  initial begin
    void'($urandom(42390));
    repeat (16) @(negedge i_core_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_core_clk);
    check(32'(o_guard_state), 32'(GUARD_UNPROGRAMMED));
    for (int n = 0; n < 4; n++) op(OP_READ, 9'h0D0 + 9'(4 * n), $urandom, 1'b0, uid_word(n));
    // Refusals: identifier write, idle, illegal mode, unaligned, unmapped, blank guard.
    op(OP_WRITE, 9'h0D0, 32'h0, 1'b1, ERASED_WORD);
    op(OP_IDLE, 9'h100, 32'h0, 1'b1, ERASED_WORD);
    op(op_mode_t'(2'h3), 9'h100, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h0D1, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h130, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h110, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h120, 32'h0, 1'b1, ERASED_WORD);
    op(OP_WRITE, 9'h114, 32'h0, 1'b1, ERASED_WORD);
    for (int n = 0; n < 4; n++) begin
      op(OP_WRITE, 9'h100 + 9'(4 * n), GUARD_OPEN, 1'b0, ERASED_WORD);
      check(32'(o_guard_state), 32'(n < 3 ? GUARD_UNPROGRAMMED : GUARD_STATE_OPEN));
    end
    op(OP_READ, 9'h108, 32'h0, 1'b0, GUARD_OPEN);
    key = {$urandom, $urandom, $urandom, $urandom};
    for (int n = 0; n < 4; n++) op(OP_WRITE, 9'h110 + 9'(4 * n), key[32*n +: 32], 1'b0, ERASED_WORD);
    for (int n = 0; n < 4; n++) begin
      check(o_link_key[32*n +: 32], key[32*n +: 32]);
      op(OP_READ, 9'h110 + 9'(4 * n), 32'h0, 1'b0, key[32*n +: 32]);
    end
    hw = $urandom;
    op(OP_WRITE, 9'h128, hw, 1'b0, ERASED_WORD);
    op(OP_READ, 9'h128, 32'h0, 1'b0, hw);
    op(OP_READ, 9'h120, 32'h0, 1'b0, ERASED_WORD);
    for (int n = 0; n < 4; n++) begin
      op(OP_WRITE, 9'h100 + 9'(4 * n), GUARD_LOCKED, 1'b0, ERASED_WORD);
      check(32'(o_guard_state), 32'(n < 3 ? GUARD_STATE_OPEN : GUARD_STATE_LOCKED));
    end
    op(OP_READ, 9'h11C, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h128, 32'h0, 1'b0, hw);
    op(OP_WRITE, 9'h128, 32'h0, 1'b1, ERASED_WORD);
    op(OP_WRITE, 9'h110, 32'h0, 1'b1, ERASED_WORD);
    op(OP_READ, 9'h128, 32'h0, 1'b0, hw);
    tally_and_finish();
  end
endmodule
